//--- design/sra_device.sv
// Purpose: device end of the serial register access port
// Assumes: link pins sampled by clk, two flops each; register file outside
// Notes: read fetch is a one-cycle request answered by reg_rdata next cycle
`timescale 1ns/1ps
module sra_device
    import sra_pkg::*;
(
    // system
    input  wire logic        clk,
    input  wire logic        reset_n,
    // link
    sra_if.dev               link,
    // register file access
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [1:0]       reg_chan,
    output logic [4:0]       reg_group,
    output logic [15:0]      reg_num,
    output logic [31:0]      reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rvalid,
    // mode control from the register file
    input  wire logic        fast_mode
);
    import sra_pkg::*;

    typedef struct packed {
        logic [1:0]  sck_s;
        logic [1:0]  sel_s;
        logic [1:0]  mosi_s;
        logic        sck_d;
        logic [5:0]  cnt;
        logic [55:0] rx;
        logic [55:0] tx;
        logic [55:0] prev;
        logic        miso;
        logic        fast;
        logic        wr;
        logic        rd;
        logic [22:0] addr;
        logic [31:0] wdata;
    } sra_dev_s;

    sra_dev_s r;
    sra_dev_s next_r;

    logic sck_rise;
    logic sck_fall;
    logic sel_act;
    logic valid_addr;
    logic [1:0] addr_chan;
    logic [4:0] addr_group;
    logic       chan_ok;
    logic       group_ok;

    // edges come from the synchronised copy; the raw pin is never read
    assign sck_rise = r.sck_s[1] & ~r.sck_d;
    assign sck_fall = ~r.sck_s[1] & r.sck_d;
    assign sel_act  = ~r.sel_s[1];

    // channel and group decode of the latched address; anything else reads zero
    assign addr_chan  = r.addr[22:21];
    assign addr_group = r.addr[20:16];
    assign valid_addr = chan_ok && group_ok;

    always_comb begin
        unique case (addr_chan)
            CHAN_0: begin
                chan_ok = 1'b1;
            end
            CHAN_1: begin
                chan_ok = 1'b1;
            end
            // reserved channel codes read zero, but reg_wr and reg_rd still fire for them
            default: begin
                chan_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        unique case (addr_group)
            GRP_LINE: begin
                group_ok = 1'b1;
            end
            GRP_WAN: begin
                group_ok = 1'b1;
            end
            GRP_CODING: begin
                group_ok = 1'b1;
            end
            GRP_HOST: begin
                group_ok = 1'b1;
            end
            GRP_GLOBAL: begin
                group_ok = 1'b1;
            end
            GRP_SECURITY: begin
                group_ok = 1'b1;
            end
            // unknown groups answer with an all-zero word
            default: begin
                group_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_r        = r;
        next_r.sck_s  = {r.sck_s[0], link.sck};
        next_r.sel_s  = {r.sel_s[0], link.port_select_n};
        next_r.mosi_s = {r.mosi_s[0], link.mosi};
        next_r.sck_d  = r.sck_s[1];
        next_r.wr     = 1'b0;
        next_r.rd     = 1'b0;
        if (!sel_act) begin
            // an aborted frame leaves no trace: count and shifter restart
            next_r.cnt  = BIT_CNT_RST;
            next_r.tx   = r.prev;
            next_r.miso = r.prev[CMD_POS];
            // mode latched only between frames so one frame never mixes timings
            next_r.fast = fast_mode;
        end else begin
            if (sck_rise) begin
                next_r.rx  = {r.rx[54:0], r.mosi_s[1]};
                next_r.cnt = r.cnt + 6'h01;
                if (r.fast) begin
                    next_r.tx   = {r.tx[54:0], 1'b0};
                    next_r.miso = r.tx[54];
                end
                // a write after a read reports zeros, not the fetched word
                if (r.cnt == BIT_CNT_RST && r.prev[CMD_POS] == CMD_READ &&
                    r.mosi_s[1] == CMD_WRITE) begin
                    if (r.fast) begin
                        next_r.tx[32:1] = 32'h0;
                    end else begin
                        next_r.tx[31:0] = 32'h0;
                    end
                end
                if (r.cnt == BIT_CNT_LAST) begin
                    next_r.cnt  = BIT_CNT_RST;
                    next_r.addr = r.rx[53:31];
                    next_r.wdata = {r.rx[30:0], r.mosi_s[1]};
                    if (r.rx[54] == CMD_WRITE) begin
                        next_r.wr   = 1'b1;
                        next_r.prev = {r.rx[54:0], r.mosi_s[1]};
                    end else begin
                        next_r.rd   = 1'b1;
                        // data field filled in when the fetch answers
                        next_r.prev = {r.rx[54:31], 32'h0};
                    end
                end
            end
            if (sck_fall && !r.fast && r.cnt != BIT_CNT_RST) begin
                next_r.tx   = {r.tx[54:0], 1'b0};
                next_r.miso = r.tx[54];
            end
        end
        // fetched word lands in the echo long before the next frame starts
        if (reg_rvalid) begin
            next_r.prev[31:0] = valid_addr ? reg_rdata : 32'h0;
        end
        if (!reset_n) begin
            next_r = '0;
            next_r.sel_s = 2'h3;
            next_r.fast  = FAST_RST;
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    assign reg_wr    = r.wr;
    assign reg_rd    = r.rd;
    assign reg_chan  = r.addr[22:21];
    assign reg_group = r.addr[20:16];
    assign reg_num   = r.addr[15:0];
    assign reg_wdata = r.wdata;
    assign link.miso_o    = r.miso;
    assign link.miso_oe_n = ~sel_act;
endmodule // sra_device

//--- design/sra_master.sv
// Purpose: master end; runs 56-bit instructions on request
// Assumes: one request at a time; other management paths idle
// Notes: link clock made here by a divider; data-out sampled on falling edge
`timescale 1ns/1ps
module sra_master
    import sra_pkg::*;
(
    // system
    input  wire logic        clk,
    input  wire logic        reset_n,
    // link
    sra_if.mst               link,
    // user request
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic [22:0] req_addr,
    input  wire logic [31:0] req_wdata,
    // answer
    output logic             rsp_valid,
    output logic [55:0]      rsp_echo
);
    import sra_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_HIGH = 2'b10,
        ST_GAP  = 2'b11
    } sra_mst_e;

    typedef struct packed {
        sra_mst_e    st;
        logic [3:0]  div;
        logic [5:0]  cnt;
        logic [55:0] tx;
        logic [55:0] rx;
        logic [1:0]  miso_s;
        logic        sck;
        logic        sel_n;
        logic        done;
    } sra_mst_s;

    sra_mst_s r;
    sra_mst_s next_r;

    always_comb begin
        next_r      = r;
        next_r.miso_s = {r.miso_s[0], link.miso_i};
        next_r.done = 1'b0;
        unique case (r.st)
            ST_IDLE: begin
                // no other management path runs meanwhile
                if (req_valid) begin
                    // data field is clocked even on reads, value unused
                    next_r.tx    = {req_write, req_addr, req_wdata};
                    next_r.sel_n = 1'b0;
                    next_r.cnt   = BIT_CNT_RST;
                    next_r.div   = DIV_RST;
                    next_r.st    = ST_LOW;
                end
            end
            ST_LOW: begin
                next_r.div = r.div + 4'h1;
                if (r.div == SCK_HALF_CYC - 4'h1) begin
                    next_r.div = DIV_RST;
                    next_r.sck = 1'b1;
                    next_r.st  = ST_HIGH;
                end
            end
            ST_HIGH: begin
                next_r.div = r.div + 4'h1;
                if (r.div == SCK_HALF_CYC - 4'h1) begin
                    next_r.div = DIV_RST;
                    next_r.sck = 1'b0;
                    // sampled late in the high phase: settled in both data-out timings
                    next_r.rx  = {r.rx[54:0], r.miso_s[1]};
                    next_r.tx  = {r.tx[54:0], 1'b0};
                    next_r.cnt = r.cnt + 6'h01;
                    next_r.st  = (r.cnt == BIT_CNT_LAST) ? ST_GAP : ST_LOW;
                end
            end
            ST_GAP: begin
                next_r.sel_n = 1'b1;
                next_r.done  = 1'b1;
                next_r.st    = ST_IDLE;
            end
        endcase
        if (!reset_n) begin
            next_r       = '0;
            next_r.st    = ST_IDLE;
            next_r.sel_n = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    assign req_ready          = (r.st == ST_IDLE) && !r.done;
    assign rsp_valid          = r.done;
    assign rsp_echo           = r.rx;
    assign link.sck           = r.sck;
    assign link.port_select_n = r.sel_n;
    assign link.mosi          = r.tx[55];
endmodule // sra_master

//--- shared/sra_if.sv
// Purpose: serial link between register master and device port
// Assumes: bench resolves the data-out wire from the enable
// Notes: miso_oe_n low means the device drives data out
`timescale 1ns/1ps
interface sra_if;
    logic sck;
    logic port_select_n;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    logic miso_i;
    modport dev (input sck, input port_select_n, input mosi,
                 output miso_o, output miso_oe_n);
    modport mst (output sck, output port_select_n, output mosi, input miso_i);
endinterface

//--- shared/sra_pkg.sv
// Purpose: shared constants for the serial register access port
// Assumes: 25 MHz system clock on both ends
// Notes: instruction layout is command, channel, group, register, data
package sra_pkg;
    localparam int unsigned INSTR_BITS   = 56;
    localparam int unsigned CMD_POS      = 55;
    localparam int unsigned CHAN_MSB     = 54;
    localparam int unsigned CHAN_LSB     = 53;
    localparam int unsigned GROUP_MSB    = 52;
    localparam int unsigned GROUP_LSB    = 48;
    localparam int unsigned REGNUM_MSB   = 47;
    localparam int unsigned REGNUM_LSB   = 32;
    localparam int unsigned DATA_BITS    = 32;
    localparam int unsigned ADDR_BITS    = 23;
    localparam logic        CMD_READ     = 1'b0;
    localparam logic        CMD_WRITE    = 1'b1;
    localparam logic [1:0]  CHAN_0       = 2'h0;
    localparam logic [1:0]  CHAN_1       = 2'h1;
    localparam logic [4:0]  GRP_LINE     = 5'h01;
    localparam logic [4:0]  GRP_WAN      = 5'h02;
    localparam logic [4:0]  GRP_CODING   = 5'h03;
    localparam logic [4:0]  GRP_HOST     = 5'h04;
    localparam logic [4:0]  GRP_GLOBAL   = 5'h1e;
    localparam logic [4:0]  GRP_SECURITY = 5'h1f;
    localparam logic [5:0]  BIT_CNT_RST  = 6'h00;
    localparam logic [5:0]  BIT_CNT_LAST = 6'h37;
    localparam logic [55:0] SHIFT_RST    = 56'h0;
    localparam logic        FAST_RST     = 1'b0;
    // link clock half period in system cycles; 30 Mbps ceiling is never approached
    localparam int unsigned SCK_HALF_NS   = 160;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam logic [3:0]  SCK_HALF_CYC  = 4'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0]  DIV_RST       = 4'h0;
endpackage

//--- verification/spi_slave_register_access_tb.sv
// Purpose: both ends joined; instruction echoes checked against a model
// Assumes: register file model answers one clk after a fetch
// Notes: slot 7 of the register file clears when fetched
`timescale 1ns/1ps
module spi_slave_register_access_tb;
    import sra_pkg::*;
    logic        clk, reset_n, fast_mode, req_valid, req_ready, req_write, rsp_valid;
    logic        reg_wr, reg_rd, reg_rvalid, have_prev;
    logic [1:0]  reg_chan;
    logic [4:0]  reg_group;
    logic [15:0] reg_num;
    logic [22:0] req_addr;
    logic [31:0] req_wdata, reg_rdata, reg_wdata;
    logic [55:0] rsp_echo, prev;
    logic [31:0] regs [8];
    logic [31:0] exp_mem [8];
    logic [4:0]  grps [6] = '{GRP_LINE, GRP_WAN, GRP_CODING, GRP_HOST, GRP_GLOBAL, GRP_SECURITY};
    int          err_total, check_count;
    int          cyc = 0;

    sra_if link ();
    // released wire shows the inverse so a stale bit never passes
    assign link.miso_i = link.miso_oe_n ? ~link.miso_o : link.miso_o;

    sra_device sra_device_i (.clk(clk), .reset_n(reset_n), .link(link), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_chan(reg_chan), .reg_group(reg_group), .reg_num(reg_num),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .fast_mode(fast_mode));
    sra_master sra_master_i (.clk(clk), .reset_n(reset_n), .link(link), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_echo(rsp_echo));
    sra_link_sva sra_link_sva_i (.clk(clk), .reset_n(reset_n), .sck(link.sck),
        .port_select_n(link.port_select_n), .mosi(link.mosi), .miso_o(link.miso_o),
        .miso_oe_n(link.miso_oe_n));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        reg_rvalid <= reg_rd;
        if (reg_rd) begin
            reg_rdata <= regs[reg_num[2:0]];
            if (reg_num[2:0] == 3'h7) regs[7] <= 32'h0;
        end
        if (reg_wr) regs[reg_num[2:0]] <= reg_wdata;
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    // expected fetch; invalid channel or group reads zero
    function automatic logic [31:0] fetch(input logic [22:0] a);
        logic ok;
        ok = a[22:21] < 2'h2 && a[20:16] inside {grps};
        fetch = ok ? exp_mem[a[2:0]] : 32'h0;
        if (ok && a[2:0] == 3'h7) exp_mem[7] = 32'h0;
    endfunction

    task automatic cmp(input logic [55:0] got, input logic [55:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [22:0] a, input logic [31:0] d);
        logic [55:0] exp;
        int          n;
        exp = {prev[55:32], (prev[55] || !w) ? prev[31:0] : 32'h0};
        @(negedge clk);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100) err_total++;
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        if (n == 1000) err_total++;
        if (have_prev) cmp(rsp_echo, exp);
        have_prev = 1'b1;
        prev = {w, a, w ? d : fetch(a)};
        if (w) exp_mem[a[2:0]] = d;
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        fast_mode = FAST_RST;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 23'h0;
        req_wdata = 32'h0;
        reg_rdata = 32'h0;
        reg_rvalid = 1'b0;
        have_prev = 1'b0;
        prev = 56'h0;
        err_total = 0;
        check_count = 0;
        for (int i = 0; i < 8; i++) begin
            regs[i] = 32'h0;
            exp_mem[i] = 32'h0;
        end
        repeat (20) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            xfer(CMD_WRITE, {i[0] ? CHAN_1 : CHAN_0, grps[i], 16'(i)}, {16'hc0de, 16'(i)});
        end
        $display("test group writes done");
        xfer(CMD_READ, {CHAN_0, GRP_LINE, 16'h0000}, 32'hffff_ffff);
        xfer(CMD_READ, {CHAN_1, GRP_WAN, 16'h0001}, 32'h0);
        xfer(CMD_READ, {2'h2, GRP_LINE, 16'h0002}, 32'h0);
        xfer(CMD_READ, {CHAN_0, 5'h05, 16'h0003}, 32'h0);
        xfer(CMD_READ, {CHAN_0, GRP_HOST, 16'h0005}, 32'h0);
        xfer(CMD_WRITE, {CHAN_0, GRP_HOST, 16'h0004}, 32'h0bad_f00d);
        $display("test pipelined reads done");
        fast_mode = 1'b1;
        xfer(CMD_READ, {CHAN_0, GRP_HOST, 16'h0004}, 32'h0);
        xfer(CMD_READ, {CHAN_1, GRP_GLOBAL, 16'h0000}, 32'h0);
        xfer(CMD_WRITE, {CHAN_0, GRP_CODING, 16'h0006}, 32'h1234_5678);
        xfer(CMD_READ, {CHAN_0, GRP_CODING, 16'h0006}, 32'h0);
        fast_mode = 1'b0;
        $display("test fast mode done");
        xfer(CMD_WRITE, {CHAN_1, GRP_SECURITY, 16'h0007}, 32'h8000_0001);
        xfer(CMD_READ, {CHAN_1, GRP_SECURITY, 16'h0007}, 32'h0);
        xfer(CMD_READ, {CHAN_1, GRP_SECURITY, 16'h0007}, 32'h0);
        xfer(CMD_READ, {CHAN_0, GRP_LINE, 16'h0000}, 32'h0);
        xfer(CMD_READ, {CHAN_0, GRP_LINE, 16'h0006}, 32'h0);
        $display("test clear on read done");
        test_done();
    end
endmodule // spi_slave_register_access_tb

//--- verification/sra_link_sva.sv
// Purpose: link protocol checks for the serial register port
// Assumes: clk samples the link; four clk per link clock half period
// Notes: watches the wire only, both ends are design code
`timescale 1ns/1ps
module sra_link_sva (
    // system
    input wire logic clk,
    input wire logic reset_n,
    // link
    input wire logic sck,
    input wire logic port_select_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic [6:0] nbits;
    logic       sck_q;

    // rising link edges seen inside the current frame
    always_ff @(posedge clk) begin
        sck_q <= sck;
        if (!reset_n || port_select_n) begin
            nbits <= 7'h00;
        end else if (sck && !sck_q) begin
            nbits <= nbits + 7'h01;
        end
    end

    sequence s_low_half;
        (!sck)[*4] ##1 sck;
    endsequence

    sequence s_frame_open;
        !sck ##1 (!port_select_n)[*8];
    endsequence

    a_frame_bits: assert property (
        $rose(port_select_n) |-> nbits == 7'h38) else $error("frame not 56 bits");
    a_bits_bound: assert property (
        !port_select_n |-> nbits <= 7'h38) else $error("too many bits in frame");
    a_oe_release: assert property (
        $rose(port_select_n) |-> ##[0:3] miso_oe_n) else $error("data-out not released");
    a_oe_enable: assert property (
        $fell(port_select_n) |-> ##[0:3] !miso_oe_n) else $error("data-out not driven");
    a_oe_idle: assert property (
        port_select_n [*4] |-> miso_oe_n) else $error("data-out driven while idle");
    a_sck_idle: assert property (
        port_select_n [*2] |-> !sck) else $error("link clock runs outside frame");
    a_frame_start: assert property (
        $fell(port_select_n) |-> s_frame_open) else $error("frame start malformed");
    a_sck_low_time: assert property (
        $fell(sck) && !port_select_n && nbits != 7'h38 |-> s_low_half)
        else $error("link clock low time wrong");
    a_mosi_stable: assert property (
        !port_select_n && sck && $past(sck) |-> $stable(mosi)) else $error("data-in moved");
endmodule // sra_link_sva
